//--- core/pap_defines.vh
// Register map, field positions, reset values and clock constants of the audio port
`ifndef PAP_DEFINES_VH
`define PAP_DEFINES_VH
`define PAP_ADDR_CTRL       3'h0
`define PAP_ADDR_CLKSEL     3'h1
`define PAP_ADDR_FRAMESEL   3'h2
`define PAP_ADDR_RATESEL    3'h3
`define PAP_ADDR_STATUS     3'h4
`define PAP_CTRL_EN         0
`define PAP_CTRL_I2S        1
`define PAP_CTRL_SLAVE      2
`define PAP_CTRL_LONG       3
`define PAP_CTRL_RESTRICT   4
`define PAP_CTRL_MCLK_EN    5
`define PAP_CTRL_RESET      6'h20
`define PAP_CLKSEL_RESET    3'h4
`define PAP_CLKSEL_MAX      3'h5
`define PAP_FRAMESEL_RESET  3'h5
`define PAP_FRAMESEL_MAX    3'h5
`define PAP_RATESEL_RESET   2'h0
`define PAP_RATE_8K         2'h0
`define PAP_RATE_16K        2'h1
`define PAP_RATE_48K        2'h2
`define PAP_STAT_TXUNDER    0
`define PAP_STAT_RXOVER     1
`define PAP_STAT_DRIVING    2
`define PAP_STAT_TXSPACE    3
`define PAP_CNT_IDLE        9'h1FF
`define PAP_I2S_LAST_BIT    5'h1F
`define PAP_SYS_KHZ         64'h61A8
`define PAP_NCO_ONE         64'h1000000
`define PAP_BCLK_BASE_HZ    64'h1F400
`define PAP_FS_8K_HZ        64'h1F40
`define PAP_FS_16K_HZ       64'h3E80
`define PAP_FS_48K_HZ       64'hBB80
`define PAP_I2S_BCLK_RATIO  64'h20
`define PAP_MCLK_FS_RATIO   64'h100
`define PAP_MCLK_HZ         (`PAP_MCLK_FS_RATIO * `PAP_FS_48K_HZ)
`define PAP_TOGGLE_INC(hz)  ((`PAP_NCO_ONE * 64'h2 * (hz)) / (`PAP_SYS_KHZ * 64'h3E8))
`define PAP_TICK_INC(hz)    ((`PAP_NCO_ONE * (hz)) / (`PAP_SYS_KHZ * 64'h3E8))
`endif

//--- core/pap_buffer.v
// Small valid/ready buffer for audio sample words
`timescale 1ns/1ps
module pap_buffer #(
	parameter WIDTH = 16,
	parameter PTRW  = 1
) (
	input  wire             clk_sys,
	input  wire             reset,
	input  wire             ce,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	localparam DEPTH = 1 << PTRW;
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [PTRW-1:0]  wrPtr_q;
	reg  [PTRW-1:0]  rdPtr_q;
	reg  [PTRW:0]    count_q;
	wire             push;
	wire             pop;

	assign inReady  = (count_q != DEPTH[PTRW:0]);
	assign outValid = (count_q != {(PTRW+1){1'b0}});
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			wrPtr_q <= {PTRW{1'b0}};
			rdPtr_q <= {PTRW{1'b0}};
			count_q <= {(PTRW+1){1'b0}};
		end
		else if (ce)
		begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end

	// Storage needs no reset; it is only read while counted valid
	always @(posedge clk_sys)
	begin
		if (ce & push)
			mem[wrPtr_q] <= inData;
	end
endmodule // pap_buffer

//--- core/pap_audio_port.v
// PCM / I2S serial audio port with master clock output
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pap_defines.vh"
module pap_audio_port #(
	parameter SAMPLE_W = 16,
	parameter BUF_PTRW = 1,
	parameter NCO_W    = 24
) (
	input  wire                clk_sys,
	input  wire                reset,
	input  wire                ce,
	input  wire [2:0]          regAddr,
	input  wire [7:0]          regWrData,
	input  wire                regWr,
	input  wire                regRd,
	output reg  [7:0]          regRdData,
	input  wire [SAMPLE_W-1:0] txData,
	input  wire                txValid,
	output wire                txReady,
	output wire [SAMPLE_W-1:0] rxData,
	output wire                rxValid,
	input  wire                rxReady,
	input  wire                bitClkIn,
	output wire                bitClkOut,
	output wire                bitClkOe_n,
	input  wire                frameSyncPinIn,
	output wire                frameSyncPinOut,
	output wire                frameSyncPinOe_n,
	input  wire                serDataIn,
	output wire                serDataOut,
	output wire                serDataOe_n,
	output wire                audioMclk
);
	reg  [5:0]          ctrl_q;
	reg  [2:0]          clkSel_q;
	reg  [2:0]          frameSel_q;
	reg  [1:0]          rateSel_q;
	reg                 txUnder_q;
	reg                 rxOver_q;
	reg  [NCO_W-1:0]    bclkAcc_q;
	reg                 bclkGen_q;
	reg  [NCO_W-1:0]    fsAcc_q;
	reg                 fsPending_q;
	reg  [NCO_W-1:0]    mclkAcc_q;
	reg                 mclk_q;
	reg  [2:0]          pinSync_q [0:2];
	reg  [2:0]          pinStab_q;
	reg                 slaveStart_q;
	reg  [8:0]          bitCnt_q;
	reg  [8:0]          bitCnt_d;
	reg                 syncOut_q;
	reg                 dout_q;
	reg                 doutOe_n_q;
	reg  [SAMPLE_W-1:0] txShift_q;
	reg  [SAMPLE_W-1:0] rxShift_q;
	wire                en;
	wire                i2s;
	wire                limitSet;
	wire                slave;
	wire                longSync;
	wire [2:0]          effClk;
	wire [2:0]          effFrame;
	wire [1:0]          effRate;
	wire [8:0]          frameLen;
	wire [63:0]         bclkIncFull;
	wire [63:0]         fsIncFull;
	wire [63:0]         mclkIncFull;
	wire [NCO_W:0]      bclkSum;
	wire [NCO_W:0]      fsSum;
	wire [NCO_W:0]      mclkSum;
	wire [2:0]          pinStabNext;
	wire                sRise;
	wire                sFall;
	wire                syncEdge;
	wire                bRise;
	wire                bFall;
	wire                launch;
	wire                sample;
	wire                frameStart;
	wire                inData;
	wire                loadWord;
	wire                wordEnd;
	wire                syncNext;
	wire                txBufValid;
	wire [SAMPLE_W-1:0] txBufData;
	wire                txPop;
	wire                rxPush;
	wire                rxBufReady;
	wire [SAMPLE_W-1:0] rxPushData;

	function [63:0] bclkInc;
		input       isI2s;
		input [2:0] code;
		input [1:0] rate;
		begin
			bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h10);
			if (isI2s)
			begin
				case (rate)
					`PAP_RATE_8K:  bclkInc = `PAP_TOGGLE_INC(`PAP_FS_8K_HZ * `PAP_I2S_BCLK_RATIO);
					`PAP_RATE_16K: bclkInc = `PAP_TOGGLE_INC(`PAP_FS_16K_HZ * `PAP_I2S_BCLK_RATIO);
					default:       bclkInc = `PAP_TOGGLE_INC(`PAP_FS_48K_HZ * `PAP_I2S_BCLK_RATIO);
				endcase
			end
			else
			begin
				case (code)
					3'h0:    bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ);
					3'h1:    bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h2);
					3'h2:    bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h4);
					3'h3:    bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h8);
					3'h5:    bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h20);
					default: bclkInc = `PAP_TOGGLE_INC(`PAP_BCLK_BASE_HZ * 64'h10);
				endcase
			end
		end
	endfunction

	function [63:0] fsInc;
		input [1:0] rate;
		begin
			case (rate)
				`PAP_RATE_8K:  fsInc = `PAP_TICK_INC(`PAP_FS_8K_HZ);
				`PAP_RATE_16K: fsInc = `PAP_TICK_INC(`PAP_FS_16K_HZ);
				default:       fsInc = `PAP_TICK_INC(`PAP_FS_48K_HZ);
			endcase
		end
	endfunction

	assign en       = ctrl_q[`PAP_CTRL_EN];
	assign i2s      = ctrl_q[`PAP_CTRL_I2S];
	assign limitSet = ctrl_q[`PAP_CTRL_RESTRICT];
	assign slave    = ctrl_q[`PAP_CTRL_SLAVE] & ~limitSet;
	assign longSync = ctrl_q[`PAP_CTRL_LONG];
	// Out-of-range clock and frame codes fall back to the reset setting; rate codes other than 8K fall back to 16K, except 48K in I2S mode without restrict
	assign effClk   = limitSet ? ((clkSel_q == `PAP_CLKSEL_MAX) ? `PAP_CLKSEL_MAX
	                  : `PAP_CLKSEL_RESET)
	                  : ((clkSel_q > `PAP_CLKSEL_MAX) ? `PAP_CLKSEL_RESET : clkSel_q);
	assign effFrame = (limitSet | (frameSel_q > `PAP_FRAMESEL_MAX)) ? `PAP_FRAMESEL_MAX
	                  : frameSel_q;
	assign effRate  = (rateSel_q == `PAP_RATE_8K) ? `PAP_RATE_8K
	                  : ((i2s & ~limitSet & (rateSel_q == `PAP_RATE_48K)) ? `PAP_RATE_48K
	                  : `PAP_RATE_16K);
	assign frameLen = 9'h8 << effFrame;

	// Master bit clock, frame tick and master clock from phase accumulators
	assign bclkIncFull = bclkInc(i2s, effClk, effRate);
	assign fsIncFull   = fsInc(effRate);
	assign mclkIncFull = `PAP_TOGGLE_INC(`PAP_MCLK_HZ);
	assign bclkSum     = {1'b0, bclkAcc_q} + {1'b0, bclkIncFull[NCO_W-1:0]};
	assign fsSum       = {1'b0, fsAcc_q} + {1'b0, fsIncFull[NCO_W-1:0]};
	assign mclkSum     = {1'b0, mclkAcc_q} + {1'b0, mclkIncFull[NCO_W-1:0]};

	// Pin inputs: three flops, a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : gPin
			assign pinStabNext[g] = (pinSync_q[g][1] == pinSync_q[g][2]) ?
			                        pinSync_q[g][2] : pinStab_q[g];
		end
	endgenerate

	assign sRise    = pinStabNext[0] & ~pinStab_q[0];
	assign sFall    = ~pinStabNext[0] & pinStab_q[0];
	// PCM frames start on a sync rise, I2S frames on the left-channel fall
	assign syncEdge = i2s ? (~pinStabNext[1] & pinStab_q[1]) : (pinStabNext[1] & ~pinStab_q[1]);
	assign bRise    = slave ? sRise : (bclkSum[NCO_W] & ~bclkGen_q);
	assign bFall    = slave ? sFall : (bclkSum[NCO_W] & bclkGen_q);
	assign launch   = en & (i2s ? bFall : bRise);
	assign sample   = en & (i2s ? bRise : bFall);

	assign frameStart = slave ? slaveStart_q
	                    : (i2s ? (bitCnt_q[4:0] == `PAP_I2S_LAST_BIT) : fsPending_q);
	// PCM data follows the first sync bit; I2S data sits one bit after word select
	assign inData   = i2s | ((bitCnt_q >= 9'h1) & (bitCnt_q <= SAMPLE_W));
	assign loadWord = i2s ? (bitCnt_d[3:0] == 4'h1) : (bitCnt_d == 9'h1);
	assign wordEnd  = i2s ? (bitCnt_q[3:0] == 4'h0) : (bitCnt_q == SAMPLE_W);

	always @*
	begin
		bitCnt_d = bitCnt_q;
		if (frameStart)
			bitCnt_d = slave ? 9'h1 : 9'h0;
		else if (i2s)
			bitCnt_d = {4'h0, bitCnt_q[4:0] + 5'h1};
		else if (bitCnt_q != `PAP_CNT_IDLE)
			bitCnt_d = bitCnt_q + 9'h1;
	end

	assign syncNext = i2s ? bitCnt_d[4]
	                  : (longSync ? (bitCnt_d < (frameLen >> 1)) : (bitCnt_d == 9'h0));

	assign txPop      = launch & loadWord;
	assign rxPush     = sample & inData & wordEnd;
	assign rxPushData = {rxShift_q[SAMPLE_W-2:0], pinStab_q[2]};

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			ctrl_q     <= `PAP_CTRL_RESET;
			clkSel_q   <= `PAP_CLKSEL_RESET;
			frameSel_q <= `PAP_FRAMESEL_RESET;
			rateSel_q  <= `PAP_RATESEL_RESET;
			txUnder_q  <= 1'b0;
			rxOver_q   <= 1'b0;
			regRdData  <= 8'h00;
		end
		else if (ce)
		begin
			regRdData <= 8'h00;
			if (regWr)
			begin
				case (regAddr)
					`PAP_ADDR_CTRL:     ctrl_q <= regWrData[5:0];
					`PAP_ADDR_CLKSEL:   clkSel_q <= regWrData[2:0];
					`PAP_ADDR_FRAMESEL: frameSel_q <= regWrData[2:0];
					`PAP_ADDR_RATESEL:  rateSel_q <= regWrData[1:0];
					default:            ;
				endcase
			end
			if (regRd)
			begin
				case (regAddr)
					`PAP_ADDR_CTRL:     regRdData <= {2'h0, ctrl_q};
					`PAP_ADDR_CLKSEL:   regRdData <= {5'h00, clkSel_q};
					`PAP_ADDR_FRAMESEL: regRdData <= {5'h00, frameSel_q};
					`PAP_ADDR_RATESEL:  regRdData <= {6'h00, rateSel_q};
					`PAP_ADDR_STATUS:   regRdData <= {4'h0, txReady, ~doutOe_n_q, rxOver_q,
					                                  txUnder_q};
					default:            regRdData <= 8'h00;
				endcase
			end
			// Write one clears; a new event in the same cycle wins
			if (regWr & (regAddr == `PAP_ADDR_STATUS) & regWrData[`PAP_STAT_TXUNDER])
				txUnder_q <= 1'b0;
			if (regWr & (regAddr == `PAP_ADDR_STATUS) & regWrData[`PAP_STAT_RXOVER])
				rxOver_q <= 1'b0;
			if (txPop & ~txBufValid)
				txUnder_q <= 1'b1;
			if (rxPush & ~rxBufReady)
				rxOver_q <= 1'b1;
		end
	end

	integer i;
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			for (i = 0; i < 3; i = i + 1)
				pinSync_q[i] <= 3'h0;
			pinStab_q <= 3'h0;
			bclkAcc_q <= {NCO_W{1'b0}};
			bclkGen_q <= 1'b0;
			fsAcc_q   <= {NCO_W{1'b0}};
			fsPending_q <= 1'b0;
			mclkAcc_q <= {NCO_W{1'b0}};
			mclk_q    <= 1'b0;
		end
		else if (ce)
		begin
			pinSync_q[0] <= {pinSync_q[0][1:0], bitClkIn};
			pinSync_q[1] <= {pinSync_q[1][1:0], frameSyncPinIn};
			pinSync_q[2] <= {pinSync_q[2][1:0], serDataIn};
			pinStab_q    <= pinStabNext;
			// Master bit clock and frame tick rest low while the port is off
			if (en & ~slave)
			begin
				bclkAcc_q <= bclkSum[NCO_W-1:0];
				if (bclkSum[NCO_W])
					bclkGen_q <= ~bclkGen_q;
				fsAcc_q <= fsSum[NCO_W-1:0];
			end
			else
			begin
				bclkAcc_q <= {NCO_W{1'b0}};
				bclkGen_q <= 1'b0;
				fsAcc_q   <= {NCO_W{1'b0}};
			end
			if (launch & frameStart & ~slave)
				fsPending_q <= 1'b0;
			if (en & ~slave & ~i2s & fsSum[NCO_W])
				fsPending_q <= 1'b1;
			else if (~en)
				fsPending_q <= 1'b0;
			// Accumulator steps are uneven at this rate; the truncated increment leaves the mean frequency slightly low
			if (ctrl_q[`PAP_CTRL_MCLK_EN])
			begin
				mclkAcc_q <= mclkSum[NCO_W-1:0];
				if (mclkSum[NCO_W])
					mclk_q <= ~mclk_q;
			end
			else
			begin
				mclkAcc_q <= {NCO_W{1'b0}};
				mclk_q    <= 1'b0;
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			slaveStart_q <= 1'b0;
			bitCnt_q     <= `PAP_CNT_IDLE;
			syncOut_q    <= 1'b0;
			dout_q       <= 1'b0;
			doutOe_n_q   <= 1'b1;
			txShift_q    <= {SAMPLE_W{1'b0}};
			rxShift_q    <= {SAMPLE_W{1'b0}};
		end
		else if (ce)
		begin
			if (~en)
			begin
				slaveStart_q <= 1'b0;
				bitCnt_q     <= `PAP_CNT_IDLE;
				syncOut_q    <= 1'b0;
				doutOe_n_q   <= 1'b1;
			end
			else
			begin
				if (slave & syncEdge)
					slaveStart_q <= 1'b1;
				else if (launch)
					slaveStart_q <= 1'b0;
				if (launch)
				begin
					bitCnt_q  <= bitCnt_d;
					syncOut_q <= syncNext;
				end
				if (launch & (i2s | ((bitCnt_d >= 9'h1) & (bitCnt_d <= SAMPLE_W))))
				begin
					doutOe_n_q <= 1'b0;
					if (txPop)
					begin
						dout_q    <= txBufValid ? txBufData[SAMPLE_W-1] : 1'b0;
						txShift_q <= txBufValid ? {txBufData[SAMPLE_W-2:0], 1'b0}
						             : {SAMPLE_W{1'b0}};
					end
					else
					begin
						dout_q    <= txShift_q[SAMPLE_W-1];
						txShift_q <= {txShift_q[SAMPLE_W-2:0], 1'b0};
					end
				end
				if (sample & inData)
					rxShift_q <= rxPushData;
				// PCM gives the line back at the sampling edge of its last bit
				if (sample & ~i2s & (bitCnt_q == SAMPLE_W))
					doutOe_n_q <= 1'b1;
			end
		end
	end

	// Loads look one count ahead, so pop uses the count being entered
	pap_buffer #(
		.WIDTH (SAMPLE_W),
		.PTRW  (BUF_PTRW)
	) uTxBuf (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.ce       (ce),
		.inData   (txData),
		.inValid  (txValid),
		.inReady  (txReady),
		.outData  (txBufData),
		.outValid (txBufValid),
		.outReady (txPop)
	);

	pap_buffer #(
		.WIDTH (SAMPLE_W),
		.PTRW  (BUF_PTRW)
	) uRxBuf (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.ce       (ce),
		.inData   (rxPushData),
		.inValid  (rxPush),
		.inReady  (rxBufReady),
		.outData  (rxData),
		.outValid (rxValid),
		.outReady (rxReady)
	);

	assign bitClkOut        = bclkGen_q;
	assign bitClkOe_n       = ~(en & ~slave);
	assign frameSyncPinOut  = syncOut_q;
	assign frameSyncPinOe_n = ~(en & ~slave);
	assign serDataOut       = dout_q;
	assign serDataOe_n      = doutOe_n_q;
	assign audioMclk        = mclk_q;
endmodule // pap_audio_port

//--- tb/pap_audio_port_checker.sv
// Port-level assertions for the audio port
`timescale 1ns/1ps
module pap_audio_port_checker (
	input wire       clk_sys,
	input wire       reset,
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire       regWr,
	input wire       regRd,
	input wire [7:0] regRdData,
	input wire       txReady,
	input wire       rxValid,
	input wire       rxReady,
	input wire       bitClkOe_n,
	input wire       frameSyncPinOut,
	input wire       frameSyncPinOe_n,
	input wire       audioMclk
);
	reg [5:0] ctrl_q;
	reg [2:0] clkSel_q;
	reg [2:0] frmSel_q;
	reg [4:0] syncHi_q;
	reg [1:0] run_q;
	wire      shortMaster = ctrl_q[0] && ctrl_q[3:1] == 3'h0 && clkSel_q == 3'h4;
	// Shadows assume legal codes only; clamped codes are not tracked
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			ctrl_q <= 6'h20;
			clkSel_q <= 3'h4;
			frmSel_q <= 3'h5;
			run_q <= 2'h0;
		end
		else
		begin
			if (regWr && regAddr == 3'h0)
				ctrl_q <= regWrData[5:0];
			if (regWr && regAddr == 3'h1)
				clkSel_q <= regWrData[2:0];
			if (regWr && regAddr == 3'h2)
				frmSel_q <= regWrData[2:0];
			if (run_q != 2'h3)
				run_q <= run_q + 2'h1;
		end
		if (!frameSyncPinOut)
			syncHi_q <= 5'h00;
		else if (syncHi_q != 5'h1F)
			syncHi_q <= syncHi_q + 5'h01;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_rdIdle; !$past(regRd) |-> regRdData == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	property p_unmapped; regRd && regAddr > 3'h4 |=> regRdData == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrlRb; regRd && regAddr == 3'h0 |=> regRdData == {2'h0, ctrl_q}; endproperty
	a_ctrlRb: assert property (p_ctrlRb) else $error("control readback wrong");
	property p_clkRb; regRd && regAddr == 3'h1 |=> regRdData == {5'h00, clkSel_q}; endproperty
	a_clkRb: assert property (p_clkRb) else $error("clock select readback wrong");
	property p_frmRb; regRd && regAddr == 3'h2 |=> regRdData == {5'h00, frmSel_q}; endproperty
	a_frmRb: assert property (p_frmRb) else $error("frame select readback wrong");
	property p_slaveClk; $past(ctrl_q[2]) && ctrl_q[2] && !ctrl_q[4] |-> bitClkOe_n; endproperty
	a_slaveClk: assert property (p_slaveClk) else $error("slave drives bit clock");
	property p_idleOe;
		$past(ctrl_q[0]) == 1'b0 && !ctrl_q[0] |-> bitClkOe_n && frameSyncPinOe_n;
	endproperty
	a_idleOe: assert property (p_idleOe) else $error("disabled port drives pins");
	property p_mclk;
		run_q == 2'h3 && ctrl_q[5] && $past(ctrl_q[5]) && $stable(audioMclk) |=> $changed(audioMclk);
	endproperty
	a_mclk: assert property (p_mclk) else $error("master clock too slow");
	property p_syncShort;
		$fell(frameSyncPinOut) && shortMaster |-> syncHi_q >= 5'h0C && syncHi_q <= 5'h0D;
	endproperty
	a_syncShort: assert property (p_syncShort) else $error("short sync width wrong");
	c_frame: cover property ($rose(frameSyncPinOut));
	c_rxPop: cover property (rxValid && rxReady);
	c_txFull: cover property (!txReady);
endmodule // pap_audio_port_checker

bind pap_audio_port pap_audio_port_checker pap_audio_port_checker_inst (
	.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txReady(txReady),
	.rxValid(rxValid), .rxReady(rxReady), .bitClkOe_n(bitClkOe_n),
	.frameSyncPinOut(frameSyncPinOut), .frameSyncPinOe_n(frameSyncPinOe_n),
	.audioMclk(audioMclk)
);

//--- tb/pap_codec_model.sv
// Behavioural codec clocking a slave PCM frame
`timescale 1ns/1ps
module pap_codec_model (
	input  wire        go,
	input  wire [15:0] txWord,
	input  wire        serDataOut,
	input  wire        serDataOe_n,
	output reg         bitClk,
	output reg         frameSync,
	output reg         serData,
	output reg  [15:0] rxWord,
	output reg         done
);
	integer i;
	initial
	begin
		bitClk = 1'b0;
		frameSync = 1'b0;
		serData = 1'b0;
		rxWord = 16'h0000;
		done = 1'b1;
	end
	// Clock only inside frames; 320 ns bit period
	always @(posedge go)
	begin
		done = 1'b0;
		// Step off the system clock edges so no pin change races a sample
		#20;
		for (i = 0; i < 20; i = i + 1)
		begin
			bitClk = 1'b1;
			frameSync = (i == 0);
			if (i >= 1 && i <= 16)
				serData = txWord[16 - i];
			else
				serData = ~serData;
			#160;
			bitClk = 1'b0;
			#120;
			// Slave path lag: read late in the bit; a released line reads as its pull-down
			if (i >= 1 && i <= 16)
				rxWord = {rxWord[14:0], serDataOut & ~serDataOe_n};
			#40;
		end
		done = 1'b1;
	end
endmodule // pap_codec_model

//--- tb/pap_audio_port_tb.sv
// Self-checking bench for the audio port
`timescale 1ns/1ps
module pap_audio_port_tb;
	reg         clk_sys = 1'b0;
	reg         reset = 1'b1;
	reg  [2:0]  regAddr = 3'h0;
	reg  [7:0]  regWrData = 8'h00;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg  [15:0] txData = 16'h0000;
	reg         txValid = 1'b0;
	reg         rxReady = 1'b0;
	reg         go = 1'b0;
	reg  [15:0] codecTx = 16'h0000;
	reg         prevLvl;
	wire [7:0]  regRdData;
	wire [15:0] rxData;
	wire [15:0] codecRx;
	wire        txReady, rxValid, bitClkOut, bitClkOe_n, syncOut, syncOe_n;
	wire        serDataOut, serDataOe_n, audioMclk, codecClk, codecSync, codecData, done;
	integer     fail_count = 0;
	integer     checks = 0;
	integer     n;
	integer     cyc;
	integer     hi;
	// Pin level comes from whichever side drives
	wire        bitClkPin = bitClkOe_n ? codecClk : bitClkOut;
	wire        syncPin = syncOe_n ? codecSync : syncOut;
	pap_audio_port pap_audio_port_inst (
		.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .bitClkIn(bitClkPin), .bitClkOut(bitClkOut),
		.bitClkOe_n(bitClkOe_n), .frameSyncPinIn(syncPin), .frameSyncPinOut(syncOut),
		.frameSyncPinOe_n(syncOe_n), .serDataIn(codecData), .serDataOut(serDataOut),
		.serDataOe_n(serDataOe_n), .audioMclk(audioMclk)
	);
	pap_codec_model pap_codec_model_inst (
		.go(go), .txWord(codecTx), .serDataOut(serDataOut), .serDataOe_n(serDataOe_n),
		.bitClk(codecClk),
		.frameSync(codecSync), .serData(codecData), .rxWord(codecRx), .done(done)
	);
	always #20 clk_sys = ~clk_sys;
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [2:0] a, input [7:0] d);
	begin
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	end
	endtask
	task rd(input [2:0] a, input [7:0] exp);
	begin
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 chk({8'h00, regRdData}, {8'h00, exp});
	end
	endtask
	task waitSync(input lvl);
	begin
		cyc = 0;
		while (syncOut !== lvl && cyc < 5000)
		begin
			@(posedge clk_sys);
			#1 cyc = cyc + 1;
		end
		if (cyc >= 5000)
		begin
			fail_count = fail_count + 1;
			tally_and_finish;
		end
	end
	endtask
	task t_regs;
	begin
		rd(3'h0, 8'h20);
		rd(3'h1, 8'h04);
		rd(3'h2, 8'h05);
		rd(3'h3, 8'h00);
		rd(3'h7, 8'h00);
		for (n = 0; n < 6; n = n + 1)
		begin
			wr(3'h1, n[7:0]);
			rd(3'h1, n[7:0]);
			wr(3'h2, n[7:0]);
			rd(3'h2, n[7:0]);
			wr(3'h3, {6'h00, n[1:0]});
			rd(3'h3, {6'h00, n[1:0]});
		end
		wr(3'h1, 8'h04);
		wr(3'h2, 8'h05);
		wr(3'h3, 8'h00);
	end
	endtask
	// Toggles over exactly 1000 edges, start sampled off the edge
	task countToggles(input useBitClk);
	begin
		n = 0;
		#1 prevLvl = useBitClk ? bitClkOut : audioMclk;
		repeat (1000)
		begin
			@(posedge clk_sys);
			#1 n = n + ((useBitClk ? bitClkOut : audioMclk) !== prevLvl);
			prevLvl = useBitClk ? bitClkOut : audioMclk;
		end
	end
	endtask
	task t_mclk;
	begin
		countToggles(1'b0);
		chk({15'h0000, n >= 982 && n <= 984}, 16'h0001);
	end
	endtask
	task t_master;
	begin
		wr(3'h0, 8'h21);
		countToggles(1'b1);
		chk({15'h0000, n >= 163 && n <= 164}, 16'h0001);
		waitSync(1'b1);
		waitSync(1'b0);
		chk({15'h0000, bitClkOe_n}, 16'h0000);
		chk({15'h0000, cyc >= 12 && cyc <= 13}, 16'h0001);
		hi = cyc;
		waitSync(1'b1);
		chk({15'h0000, hi + cyc >= 3112 && hi + cyc <= 3138}, 16'h0001);
		wr(3'h0, 8'h29);
		waitSync(1'b0);
		waitSync(1'b1);
		waitSync(1'b0);
		chk({15'h0000, cyc >= 1549 && cyc <= 1576}, 16'h0001);
		wr(3'h0, 8'h20);
		repeat (3) @(posedge clk_sys);
		#1 chk({14'h0000, bitClkOe_n, syncOe_n}, 16'h0003);
		wr(3'h0, 8'h23);
		waitSync(1'b1);
		waitSync(1'b0);
		chk({15'h0000, cyc >= 1549 && cyc <= 1576}, 16'h0001);
		wr(3'h0, 8'h35);
		#1 chk({15'h0000, bitClkOe_n}, 16'h0000);
		wr(3'h0, 8'h20);
	end
	endtask
	task t_buffer;
	begin
		@(posedge clk_sys);
		rxReady <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rxReady <= 1'b0;
		#1 chk({15'h0000, rxValid}, 16'h0000);
		wr(3'h4, 8'h03);
		@(posedge clk_sys);
		txValid <= 1'b1;
		txData <= 16'hA1B2;
		@(posedge clk_sys);
		txData <= 16'hC3D4;
		@(posedge clk_sys);
		txData <= 16'hE5F6;
		#1 chk({15'h0000, txReady}, 16'h0000);
		@(posedge clk_sys);
		txValid <= 1'b0;
		rd(3'h4, 8'h00);
	end
	endtask
	task t_slave;
	begin
		wr(3'h0, 8'h25);
		for (n = 0; n < 2; n = n + 1)
		begin
			codecTx = n ? 16'h0FF0 : 16'h9C35;
			@(posedge clk_sys);
			go <= 1'b1;
			@(posedge clk_sys);
			go <= 1'b0;
			cyc = 0;
			while (!done && cyc < 400)
			begin
				@(posedge clk_sys);
				cyc = cyc + 1;
			end
			if (cyc >= 400)
			begin
				fail_count = fail_count + 1;
				tally_and_finish;
			end
			chk({15'h0000, bitClkOe_n}, 16'h0001);
			chk({15'h0000, serDataOe_n}, 16'h0001);
			chk(codecRx, n ? 16'hC3D4 : 16'hA1B2);
		end
		repeat (4) @(posedge clk_sys);
		for (n = 0; n < 2; n = n + 1)
		begin
			chk(rxData, n ? 16'h0FF0 : 16'h9C35);
			rxReady <= 1'b1;
			@(posedge clk_sys);
			rxReady <= 1'b0;
			@(posedge clk_sys);
		end
		#1 chk({15'h0000, rxValid}, 16'h0000);
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs;
		t_mclk;
		t_master;
		t_buffer;
		t_slave;
		tally_and_finish;
	end
endmodule // pap_audio_port_tb
